//--- rtl/rgi_pkg.sv
// shared constants for the regulator i2c target and its controller
package rgi_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int FS_RATE_BPS = 400_000;
	localparam int HS_RATE_BPS = 3_400_000;
	// a bit is four quarter phases; fastest rate is a least period, so round up
	localparam int FS_QTR_CYC = (CLK_HZ + 4 * FS_RATE_BPS - 1) / (4 * FS_RATE_BPS);
	localparam int HS_QTR_CYC = (CLK_HZ + 4 * HS_RATE_BPS - 1) / (4 * HS_RATE_BPS);
	localparam int STARTUP_DELAY_US = 1000;
	localparam int STARTUP_DELAY_CYC = STARTUP_DELAY_US * (CLK_HZ / 1_000_000);

	localparam logic [7:0] REG_SETPOINT_LOW = 8'h01;
	localparam logic [7:0] REG_SETPOINT_HIGH = 8'h02;
	localparam logic [7:0] REG_CONVERTER_CONTROL = 8'h03;
	localparam logic [7:0] REG_FAULT_FLAGS = 8'h05;
	localparam logic [7:0] SETPOINT_HIGH_RST = 8'h64;
	localparam logic [7:0] CONTROL_RST = 8'h6f;
	localparam logic [7:0] FAULT_FLAGS_RST = 8'h00;
	localparam int CTL_SOFT_RESET_BIT = 7;
	localparam int FLG_THERMAL_BIT = 4;
	localparam int FLG_HICCUP_BIT = 3;
	localparam int FLG_UVLO_BIT = 0;
	localparam logic ADDR_FIXED_MSB = 1'b1;
	localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
	localparam logic [7:0] HS_MASTER_CODE = 8'h08;

	// controller command registers
	localparam logic [2:0] CREG_CMD = 3'h0;
	localparam logic [2:0] CREG_TARGET = 3'h1;
	localparam logic [2:0] CREG_REGADDR = 3'h2;
	localparam logic [2:0] CREG_WDATA = 3'h3;
	localparam logic [2:0] CREG_STATUS = 3'h4;
	localparam logic [2:0] CREG_RDATA = 3'h5;
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int CMD_HS_BIT = 2;
	localparam int CST_BUSY_BIT = 0;
	localparam int CST_NACK_BIT = 1;

	typedef enum {PH_IDLE, PH_ADDR, PH_REG, PH_WDATA, PH_RDATA, PH_SKIP} rgi_phase_t;
	typedef enum {OP_IDLE, OP_START, OP_BYTE, OP_STOP} rgi_op_t;
endpackage

//--- rtl/rgi_i2c_if.sv
// open-drain i2c wires between controller and target
`timescale 1ns/1ps
interface rgi_i2c_if;
	logic ctl_scl_o;
	logic ctl_scl_oe;
	logic ctl_sda_o;
	logic ctl_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// pull-ups: a line is low only while someone drives a low
	assign scl = !(ctl_scl_oe && !ctl_scl_o);
	assign sda = !(ctl_sda_oe && !ctl_sda_o) && !(dev_sda_oe && !dev_sda_o);
	modport ctl(output ctl_scl_o, ctl_scl_oe, ctl_sda_o, ctl_sda_oe, input scl, sda);
	modport dev(output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

//--- rtl/rgi_pin_filter.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module rgi_pin_filter #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk, // core clock
	input wire logic i_rst_n, // async reset, low
	input wire logic [W-1:0] i_d, // raw pins
	output logic [W-1:0] o_q // filtered levels
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} rgi_filt_state_t;
	rgi_filt_state_t st;
	rgi_filt_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = i_d;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		// follow only when second and third stage agree
		next_st.q = (st.s2 & st.s3) | (st.q & (st.s2 | st.s3));
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= {4{RST_VAL}};
		end else begin
			st <= next_st;
		end
	end

	assign o_q = st.q;
endmodule

//--- rtl/rgi_target.sv
// i2c target interface and register set of the step-down module
`timescale 1ns/1ps
// Functional notes
// - controller sends hs master code at 400kbps
// - master code never acked, enables hs mode
// - after repeated start, same framing, faster
// - stop leaves hs mode
// - controller keeps hs with repeated starts
// - unmapped register reads return zero
// - write: start, address, register, data
// - ack each written byte, sda low
// - commit data on ack clock falling edge
// - supply low or enable fall resets registers
// - soft reset restarts, locks writes during delay
// - low setpoint default from select resistor code
// - select pin picks active setpoint register
// - address byte: msb one, resistor bits, direction
// - register index in low bits, rest zero
// - setpoints eight bit, high defaults 0x64
// - only matching address is acknowledged
// - fault flags sticky until read or reset
// - control bit seven is soft reset
module rgi_target import rgi_pkg::*; #(
	parameter int unsigned STARTUP_CYC = STARTUP_DELAY_CYC
) (
	input wire logic I_CLK, // core clock
	input wire logic I_RST_N, // async reset, low
	rgi_i2c_if.dev BUS, // i2c wires
	input wire logic I_VOLTAGE_SELECT_PIN, // setpoint select pin
	input wire logic I_EN, // enable pin
	input wire logic I_SUPPLY_LOW, // input supply below threshold
	input wire logic [5:0] I_ADDR_CODE, // resistor decoded address
	input wire logic [7:0] I_VSET_CODE, // resistor decoded setpoint
	input wire logic I_THERMAL_WARN, // thermal warning event
	input wire logic I_HICCUP, // hiccup event
	input wire logic I_UVLO_EVT, // undervoltage event
	output logic [7:0] O_SETPOINT, // active setpoint code
	output logic [7:0] O_CONTROL, // control register
	output logic O_HS_MODE, // receiver in high-speed setting
	output logic O_STARTUP_BUSY, // writes locked during start-up
	output logic O_RESTART // pulse: new power-up sequence
);
	typedef struct packed {
		rgi_phase_t phase;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic rw_rd;
		logic [7:0] ptr;
		logic sda_oe;
		logic hs;
		logic scl_q;
		logic sda_q;
		logic en_q;
		logic [7:0] setpoint_code_low;
		logic [7:0] setpoint_code_high;
		logic [7:0] ctrl;
		logic [7:0] flags;
		logic [7:0] active;
		logic reload;
		logic restart;
		logic [31:0] delay;
	} rgi_tgt_state_t;

	rgi_tgt_state_t st;
	rgi_tgt_state_t next_st;
	logic [3:0] pins;
	logic scl;
	logic sda;
	logic vsel;
	logic en;

	rgi_pin_filter #(.W(4), .RST_VAL(4'hc)) u_pins (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_d({BUS.scl, BUS.sda, I_VOLTAGE_SELECT_PIN, I_EN}),
		.o_q(pins)
	);
	assign {scl, sda, vsel, en} = pins;

	function automatic logic [7:0] read_reg(input rgi_tgt_state_t s, input logic [7:0] a);
		case (a)
			REG_SETPOINT_LOW: read_reg = s.setpoint_code_low;
			REG_SETPOINT_HIGH: read_reg = s.setpoint_code_high;
			REG_CONVERTER_CONTROL: read_reg = s.ctrl;
			REG_FAULT_FLAGS: read_reg = s.flags;
			default: read_reg = 8'h00;
		endcase
	endfunction

	always_comb begin
		logic [7:0] ev;
		logic [7:0] d;
		logic [7:0] p;
		ev = 8'h00;
		d = 8'h00;
		p = st.ptr;
		next_st = st;
		next_st.restart = 1'b0;
		next_st.scl_q = scl;
		next_st.sda_q = sda;
		next_st.en_q = en;
		if (st.delay != 0) begin
			next_st.delay = st.delay - 32'd1;
		end
		ev[FLG_THERMAL_BIT] = I_THERMAL_WARN;
		ev[FLG_HICCUP_BIT] = I_HICCUP;
		ev[FLG_UVLO_BIT] = I_UVLO_EVT;

		if (scl && st.scl_q && st.sda_q && !sda) begin
			// start or repeated start; framing is rate independent
			next_st.phase = PH_ADDR;
			next_st.cnt = 4'd0;
			next_st.sda_oe = 1'b0;
		end else if (scl && st.scl_q && !st.sda_q && sda) begin
			next_st.phase = PH_IDLE;
			next_st.sda_oe = 1'b0;
			next_st.hs = 1'b0;
		end else if (scl && !st.scl_q && st.phase != PH_IDLE && st.phase != PH_SKIP) begin
			next_st.cnt = st.cnt + 4'd1;
			if (st.cnt < 4'd8 && st.phase != PH_RDATA) begin
				next_st.shreg = {st.shreg[6:0], sda};
			end
			if (st.cnt == 4'd8 && st.phase == PH_RDATA && sda) begin
				next_st.phase = PH_SKIP;
			end
		end else if (!scl && st.scl_q && st.phase != PH_IDLE && st.phase != PH_SKIP) begin
			if (st.cnt == 4'd8) begin
				case (st.phase)
					PH_ADDR: begin
						if (st.shreg[7:3] == HS_CODE_PREFIX) begin
							next_st.hs = 1'b1;
							next_st.phase = PH_SKIP;
						end else if (st.shreg[7:1] == {ADDR_FIXED_MSB, I_ADDR_CODE}) begin
							next_st.sda_oe = 1'b1;
							next_st.rw_rd = st.shreg[0];
						end else begin
							next_st.phase = PH_SKIP;
						end
					end
					PH_REG: begin
						next_st.ptr = st.shreg;
						next_st.sda_oe = 1'b1;
					end
					PH_WDATA: next_st.sda_oe = 1'b1;
					default: next_st.sda_oe = 1'b0;
				endcase
			end else if (st.cnt == 4'd9) begin
				next_st.sda_oe = 1'b0;
				next_st.cnt = 4'd0;
				case (st.phase)
					PH_ADDR: next_st.phase = st.rw_rd ? PH_RDATA : PH_REG;
					PH_REG: next_st.phase = PH_WDATA;
					PH_WDATA: begin
						next_st.ptr = st.ptr + 8'd1;
						// registers stay locked until the start-up delay ends
						if (st.delay == 0) begin
							case (st.ptr)
								REG_SETPOINT_LOW: next_st.setpoint_code_low = st.shreg;
								REG_SETPOINT_HIGH: next_st.setpoint_code_high = st.shreg;
								REG_CONVERTER_CONTROL: begin
									next_st.ctrl = st.shreg;
									next_st.reload = st.shreg[CTL_SOFT_RESET_BIT];
								end
								default: next_st.ctrl = st.ctrl;
							endcase
						end
					end
					default: begin
						p = st.ptr + 8'd1;
						next_st.ptr = p;
					end
				endcase
				if (next_st.phase == PH_RDATA) begin
					d = read_reg(st, p);
					if (p == REG_FAULT_FLAGS) begin
						next_st.flags = FAULT_FLAGS_RST;
					end
					next_st.sda_oe = !d[7];
					next_st.shreg = {d[6:0], 1'b0};
				end
			end else if (st.phase == PH_RDATA) begin
				next_st.sda_oe = !st.shreg[7];
				next_st.shreg = {st.shreg[6:0], 1'b0};
			end
		end

		// power-on, supply loss, enable fall and soft reset all reload defaults
		if (st.reload || I_SUPPLY_LOW || (st.en_q && !en)) begin
			next_st.setpoint_code_low = I_VSET_CODE;
			next_st.setpoint_code_high = SETPOINT_HIGH_RST;
			next_st.ctrl = CONTROL_RST;
			next_st.flags = FAULT_FLAGS_RST;
			next_st.reload = 1'b0;
			next_st.restart = 1'b1;
			next_st.delay = STARTUP_CYC;
		end
		// a fault arriving with the clearing read is kept
		next_st.flags = next_st.flags | ev;
		next_st.active = vsel ? st.setpoint_code_high : st.setpoint_code_low;
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st <= '0;
			st.reload <= 1'b1;
			st.scl_q <= 1'b1;
			st.sda_q <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign BUS.dev_sda_o = 1'b0;
	assign BUS.dev_sda_oe = st.sda_oe;
	assign O_SETPOINT = st.active;
	assign O_CONTROL = st.ctrl;
	assign O_HS_MODE = st.hs;
	assign O_STARTUP_BUSY = (st.delay != 0);
	assign O_RESTART = st.restart;
endmodule

//--- rtl/rgi_controller.sv
// i2c controller end: runs single register writes and reads
`timescale 1ns/1ps
module rgi_controller import rgi_pkg::*; (
	input wire logic I_CLK, // core clock
	input wire logic I_RST_N, // async reset, low
	rgi_i2c_if.ctl BUS, // i2c wires
	input wire logic [2:0] I_ADDR, // command register index
	input wire logic [7:0] I_WDATA, // write data
	input wire logic I_WR, // write strobe
	input wire logic I_RD, // read strobe
	output logic [7:0] O_RDATA // read data, cycle after strobe
);
	typedef struct packed {
		rgi_op_t op;
		logic [3:0] step;
		logic [1:0] q;
		logic [3:0] bit_i;
		logic [6:0] div;
		logic [7:0] tx;
		logic [7:0] rx;
		logic scl_oe;
		logic sda_oe;
		logic rd;
		logic hs_req;
		logic hs_on;
		logic [6:0] taddr;
		logic [7:0] raddr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic nack;
		logic busy;
		logic [7:0] rd_out;
	} rgi_ctl_state_t;

	rgi_ctl_state_t st;
	rgi_ctl_state_t next_st;

	// steps: 0 S, 1 master code, 2 S, 3 addr-w, 4 reg, 5 data or Sr, 6 addr-r, 7 read, 8 P
	function automatic rgi_op_t step_op(input logic [3:0] s, input logic rd);
		case (s)
			4'd0, 4'd2: step_op = OP_START;
			4'd5: step_op = rd ? OP_START : OP_BYTE;
			4'd8: step_op = OP_STOP;
			default: step_op = OP_BYTE;
		endcase
	endfunction

	function automatic logic [7:0] step_byte(input rgi_ctl_state_t s, input logic [3:0] n);
		case (n)
			4'd1: step_byte = HS_MASTER_CODE;
			4'd3: step_byte = {s.taddr, 1'b0};
			4'd4: step_byte = s.raddr;
			4'd5: step_byte = s.wdata;
			4'd6: step_byte = {s.taddr, 1'b1};
			default: step_byte = 8'hff;
		endcase
	endfunction

	always_comb begin
		logic [3:0] ns;
		ns = st.step + 4'd1;
		next_st = st;
		next_st.rd_out = 8'h00;
		if (I_RD) begin
			case (I_ADDR)
				CREG_TARGET: next_st.rd_out = {1'b0, st.taddr};
				CREG_REGADDR: next_st.rd_out = st.raddr;
				CREG_WDATA: next_st.rd_out = st.wdata;
				CREG_STATUS: next_st.rd_out = {6'h00, st.nack, st.busy};
				CREG_RDATA: next_st.rd_out = st.rdata;
				default: next_st.rd_out = 8'h00;
			endcase
		end
		if (I_WR) begin
			case (I_ADDR)
				CREG_TARGET: next_st.taddr = I_WDATA[6:0];
				CREG_REGADDR: next_st.raddr = I_WDATA;
				CREG_WDATA: next_st.wdata = I_WDATA;
				CREG_CMD: begin
					if (I_WDATA[CMD_GO_BIT] && !st.busy) begin
						next_st.busy = 1'b1;
						next_st.nack = 1'b0;
						next_st.rd = I_WDATA[CMD_READ_BIT];
						next_st.hs_req = I_WDATA[CMD_HS_BIT];
						next_st.step = I_WDATA[CMD_HS_BIT] ? 4'd0 : 4'd2;
						next_st.op = OP_START;
						next_st.q = 2'd0;
						next_st.div = 7'd0;
					end
				end
				default: next_st.taddr = st.taddr;
			endcase
		end

		if (st.op != OP_IDLE) begin
			if (st.div != 0) begin
				next_st.div = st.div - 7'd1;
			end else begin
				// master code goes at the slow rate, the rest at hs if asked
				next_st.div = st.hs_on ? 7'(HS_QTR_CYC - 1) : 7'(FS_QTR_CYC - 1);
				next_st.q = st.q + 2'd1;
				case (st.op)
					OP_START: begin
						case (st.q)
							2'd0: begin
								next_st.scl_oe = 1'b1;
								next_st.sda_oe = 1'b0;
							end
							2'd1: next_st.scl_oe = 1'b0;
							2'd2: next_st.sda_oe = 1'b1;
							default: next_st.scl_oe = 1'b1;
						endcase
					end
					OP_STOP: begin
						case (st.q)
							2'd0: begin
								next_st.scl_oe = 1'b1;
								next_st.sda_oe = 1'b1;
							end
							2'd1: next_st.scl_oe = 1'b0;
							2'd2: next_st.sda_oe = 1'b0;
							default: next_st.scl_oe = 1'b0;
						endcase
					end
					default: begin
						case (st.q)
							2'd0: begin
								next_st.scl_oe = 1'b1;
								next_st.sda_oe = (st.step != 4'd7) && (st.bit_i < 4'd8) && !st.tx[7];
								if (st.bit_i < 4'd8) begin
									next_st.tx = {st.tx[6:0], 1'b1};
								end
							end
							2'd1: next_st.scl_oe = 1'b0;
							2'd2: begin
								if (st.bit_i < 4'd8) begin
									next_st.rx = {st.rx[6:0], BUS.sda};
								end else if (BUS.sda && st.step >= 4'd3 && st.step <= 4'd6) begin
									next_st.nack = 1'b1;
								end
							end
							default: begin
								next_st.scl_oe = 1'b1;
								next_st.bit_i = st.bit_i + 4'd1;
							end
						endcase
					end
				endcase
				if (st.q == 2'd3 && (st.op != OP_BYTE || st.bit_i == 4'd8)) begin
					if (st.step == 4'd1) begin
						next_st.hs_on = 1'b1;
					end
					if (st.step == 4'd7) begin
						next_st.rdata = st.rx;
					end
					if (st.step == 4'd5 && !st.rd) begin
						ns = 4'd8;
					end
					if (next_st.nack) begin
						ns = 4'd8;
					end
					if (st.op == OP_STOP) begin
						next_st.op = OP_IDLE;
						next_st.busy = 1'b0;
						next_st.hs_on = 1'b0;
					end else begin
						// a repeated start keeps the link in hs mode
						next_st.step = ns;
						next_st.op = step_op(ns, st.rd);
						next_st.tx = step_byte(st, ns);
						next_st.bit_i = 4'd0;
					end
				end
			end
		end
	end

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign BUS.ctl_scl_o = 1'b0;
	assign BUS.ctl_scl_oe = st.scl_oe;
	assign BUS.ctl_sda_o = 1'b0;
	assign BUS.ctl_sda_oe = st.sda_oe;
	assign O_RDATA = st.rd_out;
endmodule

//--- tb/rgi_monitor.sv
// wire-level assertions on the i2c link between controller and target
`timescale 1ns/1ps
module rgi_monitor (
	input wire logic I_CLK, // core clock
	input wire logic I_RST_N, // async reset, low
	input wire logic ctl_scl_o, // controller scl data
	input wire logic ctl_scl_oe, // controller pulls scl
	input wire logic ctl_sda_o, // controller sda data
	input wire logic ctl_sda_oe, // controller pulls sda
	input wire logic dev_sda_o, // target sda data
	input wire logic dev_sda_oe, // target pulls sda
	input wire logic scl, // resolved scl
	input wire logic sda // resolved sda
);
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	property p_open_drain;
		!ctl_scl_o && !ctl_sda_o && !dev_sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open-drain data not low");
	property p_rst_quiet;
		$rose(I_RST_N) |-> !ctl_scl_oe && !ctl_sda_oe && !dev_sda_oe;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("line pulled right after reset");
	// target must not move sda while scl is high, or it forges a start or stop
	property p_ack_hold;
		dev_sda_oe && scl |=> dev_sda_oe || !scl;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("target released sda during scl high");
	property p_dev_lag;
		$changed(dev_sda_oe) |-> !scl && !$past(scl, 3);
	endproperty
	a_dev_lag: assert property (p_dev_lag) else $error("target sda change not in scl low");
	// quarter phase is at least 8 cycles even in high speed
	property p_scl_high;
		$rose(scl) |-> scl [*8];
	endproperty
	a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");
	property p_scl_low;
		$fell(scl) |-> ##[12:300] $rose(scl);
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("scl low phase out of range");
	property p_start_ctl;
		scl && $fell(sda) |-> ctl_sda_oe && !dev_sda_oe;
	endproperty
	a_start_ctl: assert property (p_start_ctl) else $error("start not made by controller");
	property p_stop_release;
		scl && $rose(sda) |=> !dev_sda_oe [*8];
	endproperty
	a_stop_release: assert property (p_stop_release) else $error("target drives sda after stop");
	c_start: cover property (scl && $fell(sda));
	c_ack: cover property (dev_sda_oe && $rose(scl));
	c_stop: cover property (scl && $rose(sda));
endmodule

//--- tb/tb_top.sv
// self-checking bench: controller and target joined over the i2c wires
`timescale 1ns/1ps
module tb_top import rgi_pkg::*;;
	localparam int STARTUP = 4000;
	localparam logic [5:0] ADDR_CODE = 6'h2a;
	localparam logic [6:0] TGT = {ADDR_FIXED_MSB, ADDR_CODE};
	localparam logic [7:0] VSET = 8'h3c;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sel = 1'b0, en = 1'b1, slow = 1'b0;
	logic therm = 1'b0, hic = 1'b0, uvlo = 1'b0, hs_seen = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, setpoint, control;
	logic hs_mode, busy_up, restart;
	int n_fail = 0, total_checks = 0, n_restart = 0;

	rgi_i2c_if bus_if();
	rgi_target #(.STARTUP_CYC(STARTUP)) rgi_target_inst (.I_CLK(clk), .I_RST_N(rst_n), .BUS(bus_if.dev),
		.I_VOLTAGE_SELECT_PIN(sel), .I_EN(en), .I_SUPPLY_LOW(slow), .I_ADDR_CODE(ADDR_CODE), .I_VSET_CODE(VSET),
		.I_THERMAL_WARN(therm), .I_HICCUP(hic), .I_UVLO_EVT(uvlo), .O_SETPOINT(setpoint), .O_CONTROL(control),
		.O_HS_MODE(hs_mode), .O_STARTUP_BUSY(busy_up), .O_RESTART(restart));
	rgi_controller rgi_controller_inst (.I_CLK(clk), .I_RST_N(rst_n), .BUS(bus_if.ctl), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata));
	rgi_monitor rgi_monitor_inst (.I_CLK(clk), .I_RST_N(rst_n), .ctl_scl_o(bus_if.ctl_scl_o),
		.ctl_scl_oe(bus_if.ctl_scl_oe), .ctl_sda_o(bus_if.ctl_sda_o), .ctl_sda_oe(bus_if.ctl_sda_oe),
		.dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (restart === 1'b1) n_restart <= n_restart + 1;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one idle cycle after each strobe keeps every signal to one assignment per step
	task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		// read data stand only in the cycle after the strobe
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
	task automatic xfer(input logic [6:0] tgt, input logic [7:0] ra, input logic [7:0] d, input logic [2:0] cmd,
		output logic [7:0] st, output logic [7:0] rv);
		int i;
		reg_wr(CREG_TARGET, {1'b0, tgt});
		reg_wr(CREG_REGADDR, ra);
		reg_wr(CREG_WDATA, d);
		reg_wr(CREG_CMD, cmd);
		hs_seen = 1'b0;
		for (i = 0; i < 20000; i++) begin
			reg_rd(CREG_STATUS, st);
			if (hs_mode === 1'b1) hs_seen = 1'b1;
			if (st[CST_BUSY_BIT] === 1'b0) break;
		end
		reg_rd(CREG_RDATA, rv);
		for (i = 0; i < 16 && hs_mode === 1'b1; i++) @(posedge clk);
	endtask
	task automatic i2c_rd(input logic [6:0] tgt, input logic [7:0] ra, input logic [7:0] exp, input logic nack);
		logic [7:0] st, rv;
		xfer(tgt, ra, 8'h00, 3'b111, st, rv);
		check({7'h0, st[CST_NACK_BIT]}, {7'h0, nack});
		check({7'h0, hs_seen}, 8'h01);
		check({7'h0, hs_mode}, 8'h00);
		if (!nack) check(rv, exp);
	endtask
	task automatic i2c_wr(input logic [7:0] ra, input logic [7:0] d, input logic [2:0] cmd);
		logic [7:0] st, rv;
		xfer(TGT, ra, d, cmd, st, rv);
		check({7'h0, st[CST_NACK_BIT]}, 8'h00);
	endtask
	task automatic wait_ready();
		int i;
		repeat (8) @(posedge clk);
		for (i = 0; i < 20000 && busy_up !== 1'b0; i++) @(posedge clk);
		check({7'h0, busy_up}, 8'h00);
	endtask

	initial begin
		repeat (99000) @(posedge clk);
		n_fail++;
		$display("mismatch at %0t: run did not finish", $time);
		finish_test();
	end

	initial begin
		int rs0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		wait_ready();
		i2c_rd(TGT, REG_SETPOINT_LOW, VSET, 1'b0);
		i2c_rd(TGT, REG_SETPOINT_HIGH, SETPOINT_HIGH_RST, 1'b0);
		i2c_rd(TGT, REG_CONVERTER_CONTROL, CONTROL_RST, 1'b0);
		i2c_rd(TGT, REG_FAULT_FLAGS, FAULT_FLAGS_RST, 1'b0);
		check(control, CONTROL_RST);
		check(setpoint, VSET);
		$display("test defaults done at %0t", $time);
		// 400kbps write, then high speed write at the low boundary
		i2c_wr(REG_SETPOINT_HIGH, 8'hff, 3'b001);
		i2c_wr(REG_SETPOINT_LOW, 8'h00, 3'b101);
		check(setpoint, 8'h00);
		sel <= 1'b1;
		// pin filter plus output register
		repeat (8) @(posedge clk);
		check(setpoint, 8'hff);
		i2c_rd(TGT, REG_SETPOINT_HIGH, 8'hff, 1'b0);
		$display("test writes done at %0t", $time);
		i2c_rd(TGT, 8'h04, 8'h00, 1'b0);
		i2c_rd(TGT, 8'h0a, 8'h00, 1'b0);
		i2c_wr(8'h09, 8'h33, 3'b101);
		i2c_rd(TGT, REG_SETPOINT_LOW, 8'h00, 1'b0);
		i2c_rd({1'b0, ADDR_CODE}, REG_SETPOINT_HIGH, 8'h00, 1'b1);
		i2c_rd(TGT ^ 7'h01, REG_SETPOINT_HIGH, 8'h00, 1'b1);
		$display("test refusals done at %0t", $time);
		therm <= 1'b1;
		repeat (4) @(posedge clk);
		therm <= 1'b0;
		i2c_rd(TGT, REG_FAULT_FLAGS, 8'h10, 1'b0);
		i2c_rd(TGT, REG_FAULT_FLAGS, 8'h00, 1'b0);
		hic <= 1'b1;
		uvlo <= 1'b1;
		repeat (4) @(posedge clk);
		hic <= 1'b0;
		uvlo <= 1'b0;
		i2c_rd(TGT, REG_FAULT_FLAGS, 8'h09, 1'b0);
		$display("test flags done at %0t", $time);
		rs0 = n_restart;
		i2c_wr(REG_CONVERTER_CONTROL, 8'h80, 3'b101);
		check(control, CONTROL_RST);
		check(setpoint, SETPOINT_HIGH_RST);
		check({7'h0, busy_up}, 8'h01);
		check(8'(n_restart - rs0), 8'h01);
		// lands inside the start-up delay, so it is acked but dropped
		i2c_wr(REG_SETPOINT_HIGH, 8'h11, 3'b101);
		wait_ready();
		i2c_rd(TGT, REG_SETPOINT_HIGH, SETPOINT_HIGH_RST, 1'b0);
		$display("test soft reset done at %0t", $time);
		i2c_wr(REG_CONVERTER_CONTROL, 8'h2f, 3'b101);
		check(control, 8'h2f);
		en <= 1'b0;
		wait_ready();
		en <= 1'b1;
		check(control, CONTROL_RST);
		i2c_wr(REG_CONVERTER_CONTROL, 8'h2f, 3'b101);
		check(control, 8'h2f);
		slow <= 1'b1;
		repeat (4) @(posedge clk);
		slow <= 1'b0;
		wait_ready();
		check(control, CONTROL_RST);
		$display("test reset sources done at %0t", $time);
		finish_test();
	end
endmodule
